// >>> verilog/parity_report_pkg.sv
package parity_report_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int STS_W = 4;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_CLEAR = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 4'hC;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_PRI_RESP_EN = 0;
	localparam int CTRL_SEC_RESP_EN = 1;
	localparam int CTRL_PRI_PIN = 8;
	localparam int CTRL_SEC_PIN = 9;
	localparam int STS_SEC_DETECT = 0;
	localparam int STS_PRI_MASTER = 1;
	localparam int STS_SEC_MASTER = 2;
	localparam int STS_PERR_SENT = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [STS_W-1:0] STS_RST = 4'h0;
	localparam logic [STS_W-1:0] IRQ_EN_RST = 4'h0;

	// ----------------------------------------------------------------
	// timing: parity error pin follows the data phase by bus clocks
	// ----------------------------------------------------------------
	localparam int PERR_DELAY_CYC = 2;

	typedef enum logic [1:0] {
		XFER_READ = 2'h0,
		XFER_POSTED = 2'h1,
		XFER_DELAYED = 2'h2
	} xfer_e;

endpackage

// >>> verilog/perr_if.sv
`timescale 1ns/1ps
interface perr_if;
	logic req;
	logic pin_o;
	logic pin_oe;

	modport ctl (
		output req,
		input pin_o,
		input pin_oe
	);
	modport drv (
		input req,
		output pin_o,
		output pin_oe
	);
endinterface

// >>> verilog/perr_drive.sv
`timescale 1ns/1ps
module perr_drive #(
	parameter int DELAY = parity_report_pkg::PERR_DELAY_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	perr_if.drv bus
);
	import parity_report_pkg::*;

	// ----------------------------------------------------------------
	// delay line: stage DELAY-1 drives low, the stage after it drives
	// high one clock so the shared line is returned before release
	// ----------------------------------------------------------------
	logic [DELAY:0] stage_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stage_reg <= '0;
		end else begin
			stage_reg <= {stage_reg[DELAY-1:0], bus.req};
		end
	end

	assign bus.pin_o = !stage_reg[DELAY-1];
	assign bus.pin_oe = stage_reg[DELAY-1] | stage_reg[DELAY];
endmodule

// >>> verilog/bridge_parity_report.sv
`timescale 1ns/1ps
// Operation
// - secondary detect bit: secondary error, down read or up write.
// - primary master bit sets only while mastering the primary bus.
// - primary master bit sets only with the primary response enable on.
// - primary master bit sets on a sampled primary pin or own error.
// - primary master bit sets only for upstream transfers.
// - secondary master bit sets only while mastering the secondary bus.
// - secondary master bit sets only with secondary response enable on.
// - secondary master bit sets on sampled secondary pin or own error.
// - secondary master bit sets only for downstream transfers.
// - primary pin driven only as write target or read initiator.
// - primary pin asserts only with the primary response enable on.
// - primary pin: own primary error or forwarded delayed write error.
// - the error pin asserts two clocks after the data phase.
// - forwarded delayed write error needs both response enables.
module bridge_parity_report (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [parity_report_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [parity_report_pkg::DATA_W-1:0] i_avs_writedata,
	output logic [parity_report_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_dphase_done,
	input wire parity_report_pkg::xfer_e i_xfer_type,
	input wire logic i_dir_up,
	input wire logic i_pri_master,
	input wire logic i_sec_master,
	input wire logic i_pri_par_err,
	input wire logic i_sec_par_err,
	input wire logic i_dw_completion,
	input wire logic i_upstream_side_parity_err_n,
	output logic o_upstream_side_parity_err_n,
	output logic o_upstream_side_parity_err_oe,
	input wire logic i_downstream_side_parity_err_n,
	output logic o_irq
);
	import parity_report_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic is_write(input xfer_e t);
		is_write = (t == XFER_POSTED) || (t == XFER_DELAYED);
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic pri_pin_meta_reg;
	logic pri_pin_low_reg;
	logic sec_pin_meta_reg;
	logic sec_pin_low_reg;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pri_pin_meta_reg <= 1'b0;
			pri_pin_low_reg <= 1'b0;
			sec_pin_meta_reg <= 1'b0;
			sec_pin_low_reg <= 1'b0;
		end else begin
			pri_pin_meta_reg <= !i_upstream_side_parity_err_n;
			pri_pin_low_reg <= pri_pin_meta_reg;
			sec_pin_meta_reg <= !i_downstream_side_parity_err_n;
			sec_pin_low_reg <= sec_pin_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [1:0] ctrl_reg;
	logic [STS_W-1:0] status_reg;
	logic [STS_W-1:0] status_next;
	logic [STS_W-1:0] irq_en_reg;
	logic ack_reg;
	logic pri_en;
	logic sec_en;
	logic req;
	logic wr_ack;
	logic [STS_W-1:0] clr;

	assign pri_en = ctrl_reg[CTRL_PRI_RESP_EN];
	assign sec_en = ctrl_reg[CTRL_SEC_RESP_EN];
	assign req = i_avs_read | i_avs_write;
	// one wait state: the request is taken on the second edge
	assign o_avs_waitrequest = req & !ack_reg;
	assign wr_ack = i_avs_write & ack_reg;
	assign clr = (wr_ack && hit(i_avs_address, OFS_CLEAR)) ?
		i_avs_writedata[STS_W-1:0] : '0;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & !ack_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_reg <= CTRL_RST;
			irq_en_reg <= IRQ_EN_RST;
		end else if (wr_ack) begin
			if (hit(i_avs_address, OFS_CTRL)) begin
				ctrl_reg <= i_avs_writedata[1:0];
			end
			if (hit(i_avs_address, OFS_IRQ_EN)) begin
				irq_en_reg <= i_avs_writedata[STS_W-1:0];
			end
		end
	end

	// read data is loaded in the wait cycle so it stands at the taking edge
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read && !ack_reg) begin
			o_avs_readdata <= '0;
			if (hit(i_avs_address, OFS_CTRL)) begin
				o_avs_readdata[1:0] <= ctrl_reg;
				o_avs_readdata[CTRL_PRI_PIN] <= pri_pin_low_reg;
				o_avs_readdata[CTRL_SEC_PIN] <= sec_pin_low_reg;
			end
			if (hit(i_avs_address, OFS_STATUS)) begin
				o_avs_readdata[STS_W-1:0] <= status_reg;
			end
			if (hit(i_avs_address, OFS_IRQ_EN)) begin
				o_avs_readdata[STS_W-1:0] <= irq_en_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// event decode
	// ----------------------------------------------------------------
	logic sec_detect_evt;
	logic pri_master_evt;
	logic sec_master_evt;
	logic perr_own_evt;
	logic perr_fwd_evt;
	logic perr_req;

	assign sec_detect_evt = i_dphase_done && i_sec_par_err &&
		((i_xfer_type == XFER_READ && !i_dir_up) ||
		(is_write(i_xfer_type) && i_dir_up));

	assign pri_master_evt = i_pri_master && i_dir_up && pri_en &&
		(pri_pin_low_reg || (i_dphase_done && i_pri_par_err));

	assign sec_master_evt = i_sec_master && !i_dir_up && sec_en &&
		(sec_pin_low_reg || (i_dphase_done && i_sec_par_err));

	// own primary error, target write or read initiator
	assign perr_own_evt = i_dphase_done && i_pri_par_err && pri_en &&
		((is_write(i_xfer_type) && !i_dir_up) ||
		(i_xfer_type == XFER_READ && i_dir_up));

	// error passed back on a downstream delayed write
	assign perr_fwd_evt = i_dw_completion && sec_pin_low_reg &&
		i_xfer_type == XFER_DELAYED && !i_dir_up &&
		!i_pri_par_err && pri_en && sec_en;

	assign perr_req = perr_own_evt | perr_fwd_evt;

	// ----------------------------------------------------------------
	// sticky status
	// ----------------------------------------------------------------
	logic [STS_W-1:0] set_vec;

	assign set_vec = {perr_req, sec_master_evt, pri_master_evt,
		sec_detect_evt};

	// set wins over a simultaneous clear
	always_comb begin
		status_next = (status_reg & ~clr) | set_vec;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_reg <= STS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(status_next & irq_en_reg);
		end
	end

	// ----------------------------------------------------------------
	// primary error pin
	// ----------------------------------------------------------------
	perr_if pif ();

	assign pif.req = perr_req;

	perr_drive #(
		.DELAY(PERR_DELAY_CYC)
	) u_perr_drive (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.bus(pif.drv)
	);

	assign o_upstream_side_parity_err_n = pif.pin_o;
	assign o_upstream_side_parity_err_oe = pif.pin_oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	logic pin_low;
	assign pin_low = o_upstream_side_parity_err_oe &&
		!o_upstream_side_parity_err_n;

	sequence s_clear_one(int b);
		wr_ack && hit(i_avs_address, OFS_CLEAR) && i_avs_writedata[b];
	endsequence

	sequence s_no_set(int b);
		!set_vec[b];
	endsequence

	a_sec_detect_set: assert property (
		(i_dphase_done && i_sec_par_err && !i_dir_up &&
		i_xfer_type == XFER_READ) |=> status_reg[STS_SEC_DETECT])
		else $error("secondary detect bit missed a downstream read");

	a_sec_detect_cause: assert property (
		$rose(status_reg[STS_SEC_DETECT]) |->
		$past(i_dphase_done && i_sec_par_err &&
		(i_dir_up == is_write(i_xfer_type))))
		else $error("secondary detect bit set without cause");

	a_pri_master_role: assert property (
		$rose(status_reg[STS_PRI_MASTER]) |->
		$past(i_pri_master && i_dir_up))
		else $error("primary master bit set while not primary master");

	a_pri_master_en: assert property (
		$rose(status_reg[STS_PRI_MASTER]) |-> $past(pri_en))
		else $error("primary master bit set with response disabled");

	a_pri_master_pin: assert property (
		(i_pri_master && i_dir_up && pri_en && pri_pin_low_reg) |=>
		status_reg[STS_PRI_MASTER])
		else $error("sampled primary pin did not set master bit");

	a_pri_master_down: assert property (
		(!i_dir_up && !status_reg[STS_PRI_MASTER] && !clr[1]) |=>
		!status_reg[STS_PRI_MASTER])
		else $error("primary master bit set on downstream transfer");

	a_sec_master_set: assert property (
		(i_sec_master && !i_dir_up && sec_en && i_dphase_done &&
		i_sec_par_err) |=> status_reg[STS_SEC_MASTER])
		else $error("secondary master bit missed own error");

	a_sec_master_gate: assert property (
		$rose(status_reg[STS_SEC_MASTER]) |->
		$past(i_sec_master && sec_en && !i_dir_up))
		else $error("secondary master bit set out of role");

	a_pri_master_set: assert property (
		(i_pri_master && i_dir_up && pri_en && i_dphase_done &&
		i_pri_par_err) |=> status_reg[STS_PRI_MASTER])
		else $error("primary master bit missed own error");

	a_sec_master_pin: assert property (
		(i_sec_master && !i_dir_up && sec_en && sec_pin_low_reg) |=>
		status_reg[STS_SEC_MASTER])
		else $error("sampled secondary pin did not set master bit");

	a_sec_master_up: assert property (
		(i_dir_up && !status_reg[STS_SEC_MASTER] &&
		!clr[STS_SEC_MASTER]) |=> !status_reg[STS_SEC_MASTER])
		else $error("secondary master bit set on upstream transfer");

	a_sec_detect_up: assert property (
		(i_dphase_done && i_sec_par_err && i_dir_up &&
		is_write(i_xfer_type)) |=> status_reg[STS_SEC_DETECT])
		else $error("secondary detect bit missed an upstream write");

	a_pin_oe_cause: assert property (
		o_upstream_side_parity_err_oe |->
		($past(perr_req, 2) || $past(perr_req, 3)))
		else $error("primary error pin driven without recent cause");

	a_pin_delay: assert property (
		perr_req |-> ##2 pin_low ##1 o_upstream_side_parity_err_oe)
		else $error("primary error pin not asserted two clocks later");

	a_pin_cause: assert property (
		$rose(pin_low) |-> $past(pri_en, 2) && $past(perr_req, 2))
		else $error("primary error pin asserted without enabled cause");

	a_pin_role: assert property (
		pin_low |-> $past((i_dphase_done || i_dw_completion) &&
		(i_dir_up != is_write(i_xfer_type)), 2))
		else $error("primary error pin asserted outside its role");

	a_pin_forward: assert property (
		(i_dw_completion && sec_pin_low_reg && !i_dir_up &&
		i_xfer_type == XFER_DELAYED && !i_pri_par_err &&
		pri_en && sec_en) |-> ##2 pin_low)
		else $error("forwarded delayed write error not signalled");

	a_sts_sticky: assert property (
		(status_reg[STS_SEC_DETECT] && !clr[STS_SEC_DETECT]) |=>
		status_reg[STS_SEC_DETECT])
		else $error("status bit dropped without a clear");

	a_sts_clear: assert property (
		(s_clear_one(STS_PRI_MASTER) and s_no_set(STS_PRI_MASTER)) |=>
		!status_reg[STS_PRI_MASTER])
		else $error("status bit survived a clear");

	a_bus_wait: assert property (
		(req && !ack_reg) |-> o_avs_waitrequest ##1
		(!req || !o_avs_waitrequest))
		else $error("waitrequest did not drop after one wait state");

	a_irq_level: assert property (
		$stable(irq_en_reg) |-> (o_irq == |(status_reg & irq_en_reg)))
		else $error("interrupt does not follow enabled status");

endmodule

// >>> tb/pci_bus_agent.sv
`timescale 1ns/1ps
module pci_bus_agent (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pri_pulse,
	input wire logic i_sec_pulse,
	input wire logic i_dev_pin_n,
	input wire logic i_dev_pin_oe,
	output logic o_pri_pin_n,
	output logic o_sec_pin_n
);
	logic pri_low_reg;
	logic sec_low_reg;

	// a reporting target's error line goes low one clock after its pulse and stays low for as long as the pulse lasts
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pri_low_reg <= 1'b0;
			sec_low_reg <= 1'b0;
		end else begin
			pri_low_reg <= i_pri_pulse;
			sec_low_reg <= i_sec_pulse;
		end
	end

	// pull-ups: an undriven line reads high, any low driver wins
	assign o_pri_pin_n = !pri_low_reg && !(i_dev_pin_oe && !i_dev_pin_n);
	assign o_sec_pin_n = !sec_low_reg;
endmodule

// >>> tb/test_bridge_parity_report.sv
`timescale 1ns/1ps
module test_bridge_parity_report;
	import parity_report_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [ADDR_W-1:0] adr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [DATA_W-1:0] wdat = '0;
	logic [DATA_W-1:0] rdat;
	logic [DATA_W-1:0] v;
	logic wreq;
	xfer_e typ = XFER_READ;
	logic dph = 1'b0, up = 1'b0, pm = 1'b0, sm = 1'b0, pe = 1'b0, se = 1'b0;
	logic dwc = 1'b0, ppul = 1'b0, spul = 1'b0, seen;
	logic pin_o, pin_oe, pri_pin, sec_pin, irq;
	int failures = 0;
	int checks_done = 0;
	int seed = 50009;
	int exp_sts;

	bridge_parity_report bridge_parity_report_i (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.i_dphase_done(dph), .i_xfer_type(typ), .i_dir_up(up),
		.i_pri_master(pm), .i_sec_master(sm), .i_pri_par_err(pe),
		.i_sec_par_err(se), .i_dw_completion(dwc),
		.i_upstream_side_parity_err_n(pri_pin),
		.o_upstream_side_parity_err_n(pin_o),
		.o_upstream_side_parity_err_oe(pin_oe),
		.i_downstream_side_parity_err_n(sec_pin), .o_irq(irq)
	);

	pci_bus_agent pci_bus_agent_i (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pri_pulse(ppul),
		.i_sec_pulse(spul), .i_dev_pin_n(pin_o), .i_dev_pin_oe(pin_oe),
		.o_pri_pin_n(pri_pin), .o_sec_pin_n(sec_pin)
	);

	initial forever #5 i_clk = ~i_clk;

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task report_and_stop;
		if (failures == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
		checks_done++;
		if (got !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, got);
		end
	endtask

	// waitrequest is combinational, so look at it once it has settled
	task bus(input logic w, input logic [ADDR_W-1:0] a, input int d);
		@(posedge i_clk);
		adr <= a;
		wdat <= DATA_W'(d);
		rd <= !w;
		wr <= w;
		#1;
		while (wreq !== 1'b0) begin
			@(posedge i_clk);
			#1;
		end
		@(posedge i_clk);
		v = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task ev(input int t, input logic u, input logic p_e, input logic s_e,
		input logic [1:0] en);
		logic b3;
		@(posedge i_clk);
		dph <= 1'b1;
		typ <= xfer_e'(t);
		up <= u;
		pe <= p_e;
		se <= s_e;
		pm <= 1'($random(seed));
		sm <= 1'($random(seed));
		#1;
		exp_sts = 0;
		if (s_e && ((t == 0) != u)) exp_sts += 1;
		if (p_e && u && pm && en[0]) exp_sts += 2;
		if (s_e && !u && sm && en[1]) exp_sts += 4;
		b3 = p_e && en[0] && ((t == 0) == u);
		if (b3) exp_sts += 8;
		@(posedge i_clk);
		dph <= 1'b0;
		pe <= 1'b0;
		se <= 1'b0;
		#1;
		chk("error pin", pri_pin, 1'b1);
		@(posedge i_clk);
		#1;
		chk("error pin", pri_pin, !b3);
		chk("pin enable", pin_oe, b3);
		repeat (2) @(posedge i_clk);
		#1;
		chk("pin enable", pin_oe, 1'b0);
		bus(1'b0, OFS_STATUS, 0);
		chk("status", v, exp_sts);
	endtask

	initial begin
		#200000;
		failures++;
		report_and_stop;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge i_clk);
		chk("pin enable", pin_oe, 1'b0);
		chk("irq", irq, 1'b0);
		i_rst_n <= 1'b1;
		for (int a = 0; a < 16; a += 2) begin
			bus(1'b0, 4'(a), 0);
			chk("reset read", v, 0);
		end
		// every type, direction, error bus and enable pair
		for (int c = 0; c < 48; c++) begin
			bus(1'b1, OFS_CTRL, c % 4);
			ev((c / 4) % 3, (c / 12) % 2, c < 24, c >= 24, 2'(c % 4));
			bus(1'b1, OFS_CLEAR, 'hF);
			bus(1'b0, OFS_STATUS, 0);
			chk("status", v, 0);
		end
		// error reported by the far target through its pin
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, OFS_CTRL, k[0] ? (k[1] ? 2 : 1) : 0);
			up <= !k[1];
			pm <= !k[1];
			sm <= k[1];
			ppul <= !k[1];
			spul <= k[1];
			@(posedge i_clk);
			ppul <= 1'b0;
			spul <= 1'b0;
			repeat (6) @(posedge i_clk);
			bus(1'b0, OFS_STATUS, 0);
			chk("status", v, k[0] ? (k[1] ? 4 : 2) : 0);
			pm <= 1'b0;
			sm <= 1'b0;
			bus(1'b1, OFS_CLEAR, 'hF);
		end
		// delayed write completion error forwarded to the primary pin
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, OFS_CTRL, k ? 3 : 1);
			dwc <= 1'b1;
			typ <= XFER_DELAYED;
			up <= 1'b0;
			sm <= 1'b1;
			spul <= 1'b1;
			@(posedge i_clk);
			spul <= 1'b0;
			seen = 1'b0;
			repeat (8) begin
				@(posedge i_clk);
				#1;
				if (pri_pin === 1'b0) seen = 1'b1;
			end
			chk("forwarded pin", seen, k);
			@(posedge i_clk);
			dwc <= 1'b0;
			sm <= 1'b0;
			bus(1'b0, OFS_STATUS, 0);
			chk("status", v, k ? 12 : 0);
			bus(1'b1, OFS_CLEAR, 'hF);
		end
		// interrupt raise, mask, clear; read-only and write-only places
		bus(1'b1, OFS_IRQ_EN, 1);
		bus(1'b0, OFS_IRQ_EN, 0);
		chk("irq enable", v, 1);
		bus(1'b1, OFS_CTRL, 0);
		ev(0, 1'b0, 1'b0, 1'b1, 2'h0);
		chk("irq", irq, 1'b1);
		bus(1'b1, OFS_STATUS, 0);
		bus(1'b0, OFS_STATUS, 0);
		chk("status", v, 1);
		bus(1'b0, OFS_CLEAR, 0);
		chk("clear read", v, 0);
		bus(1'b1, OFS_IRQ_EN, 0);
		repeat (2) @(posedge i_clk);
		chk("irq", irq, 1'b0);
		bus(1'b1, OFS_IRQ_EN, 1);
		repeat (2) @(posedge i_clk);
		chk("irq", irq, 1'b1);
		bus(1'b1, OFS_CLEAR, 1);
		repeat (2) @(posedge i_clk);
		chk("irq", irq, 1'b0);
		// both far lines held low: synced view in control, no status
		ppul <= 1'b1;
		spul <= 1'b1;
		repeat (3) @(posedge i_clk);
		bus(1'b0, OFS_CTRL, 0);
		chk("pin view", v, 32'h300);
		ppul <= 1'b0;
		spul <= 1'b0;
		bus(1'b0, OFS_STATUS, 0);
		chk("status", v, 0);
		report_and_stop;
	end
endmodule
